/* File: design/uart_regs_pkg.sv */
package uart_regs_pkg;
  // Register offsets on the three-bit address port
  localparam logic [2:0] OFF_DATA       = 3'h0;  // Receive buffer, transmit holding, divisor low
  localparam logic [2:0] OFF_IRQ_ENABLE = 3'h1;  // Interrupt enable, divisor high
  localparam logic [2:0] OFF_IRQ_ID     = 3'h2;  // Identification on read, FIFO control on write
  localparam logic [2:0] OFF_LINE_CTRL  = 3'h3;
  localparam logic [2:0] OFF_MODEM_CTRL = 3'h4;
  localparam logic [2:0] OFF_LINE_STAT  = 3'h5;
  localparam logic [2:0] OFF_MODEM_STAT = 3'h6;
  localparam logic [2:0] OFF_SCRATCH    = 3'h7;

  // FIFO control field positions, and the divisor select bit of line control
  localparam int FCR_ENABLE_BIT  = 0;
  localparam int FCR_RX_FLUSH    = 1;
  localparam int FCR_TX_FLUSH    = 2;
  localparam int FCR_READY_MODE  = 3;
  localparam int FCR_TRIG_LSB    = 6;
  localparam int LCR_DIV_SELECT  = 7;

  // Interrupt enable field positions
  localparam int IER_RX_DATA     = 0;
  localparam int IER_TX_EMPTY    = 1;
  localparam int IER_LINE_STAT   = 2;
  localparam int IER_MODEM_STAT  = 3;

  // Receive trigger levels in bytes
  localparam logic [4:0] TRIG_LEVEL_0 = 5'h01;
  localparam logic [4:0] TRIG_LEVEL_1 = 5'h04;
  localparam logic [4:0] TRIG_LEVEL_2 = 5'h08;
  localparam logic [4:0] TRIG_LEVEL_3 = 5'h0E;

  // FIFO geometry
  localparam int         FIFO_DEPTH  = 16;
  localparam int         PTR_W       = 4;
  localparam int         CNT_W       = 5;
  localparam int         RX_W        = 11;                  // Data byte plus three error flags
  localparam logic [4:0] FIFO_FULL   = 5'h10;
  localparam logic [4:0] CHAR_FULL   = 5'h01;               // Unbuffered mode holds one byte

  // Interrupt identification codes, bits 3:1
  localparam logic [2:0] ID_LINE_STAT = 3'h3;
  localparam logic [2:0] ID_RX_DATA   = 3'h2;
  localparam logic [2:0] ID_TX_EMPTY  = 3'h1;
  localparam logic [2:0] ID_MODEM     = 3'h0;

  // Reset values
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [15:0] RST_DIVISOR = 16'h0000;
  localparam logic [5:0]  RST_MCR     = 6'h00;
  localparam logic [1:0]  RST_TRIG    = 2'h0;
endpackage : uart_regs_pkg

/* File: design/fifo_store.sv */
`timescale 1ns/1ps
// Sixteen-word store with one write port and one registered read port.
// Read address is the pointer of the next cycle, so the output always shows the current head.
module fifo_store
  import uart_regs_pkg::*;
#(
  parameter int W = RX_W
) (
  input  wire logic             i_mclk,
  input  wire logic             i_we,
  input  wire logic [PTR_W-1:0] i_waddr,
  input  wire logic [W-1:0]     i_wdata,
  input  wire logic [PTR_W-1:0] i_raddr,
  output logic      [W-1:0]     o_rdata
);
  logic [W-1:0] mem [FIFO_DEPTH];  // Storage, no reset needed
  wire          fwd = i_we && (i_waddr == i_raddr);  // Write lands on the head being read

  // Write port
  always_ff @(posedge i_mclk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // Registered read, forwarding a same-cycle write so a fresh head is never stale
  always_ff @(posedge i_mclk) begin
    o_rdata <= fwd ? i_wdata : mem[i_raddr];
  end
endmodule : fifo_store

/* File: design/uart_register_map_fifo_control.sv */
`timescale 1ns/1ps
// Contract
// - Offset 2: write FIFO control, read identification
// - Control bit 0 enables both FIFOs
// - Other control bits need bit 0 written
// - Changing bit 0 empties both FIFOs
// - Bit 1 flushes receive FIFO, self-clearing
// - Bit 2 flushes transmit FIFO, self-clearing
// - Bit 3 selects ready-signal mode 1
// - Bits 4 and 5 reserved, no function
// - Bits 7:6 pick trigger 1/4/8/14
// - Enable bits 0-3 gate interrupts; 4-7 zero
// - Bit 0 is LSB, sent first
// - Unbuffered mode: FIFO-only status bits zero
// - Divisor select remaps offsets 0 and 1
// - Offset 0: read receive, write transmit
module uart_register_map_fifo_control
  import uart_regs_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic [2:0]  i_addr,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic [7:0]  i_wr_data,
  output logic      [7:0]  o_rd_data,
  input  wire logic        i_rx_valid,
  input  wire logic [7:0]  i_rx_data,
  input  wire logic [2:0]  i_rx_err,
  output logic             o_tx_valid,
  output logic      [7:0]  o_tx_data,
  input  wire logic        i_tx_ready,
  input  wire logic        i_tx_shift_empty,
  input  wire logic [3:0]  i_modem_lines,
  output logic             o_irq,
  output logic             o_receive_ready_out_n,
  output logic             o_transmit_ready_out_n,
  output logic      [15:0] o_baud_divisor,
  output logic      [7:0]  o_line_control,
  output logic      [5:0]  o_modem_control
);
  // Programmed state, sticky status flags and edge history
  logic [3:0]       irq_enable;       // Four enables; upper nibble is not stored
  logic             fifo_en;          // Buffered mode
  logic             ready_mode_bit;   // Ready-signal mode select
  logic [1:0]       trig_sel;         // Receive trigger select
  logic [7:0]       scratch;          // Host scratch byte
  logic             overrun;          // Sticky overrun flag
  logic [3:0]       msr_delta;        // Sticky modem change flags
  logic [3:0]       modem_prev;       // Previous modem line levels
  logic             thre_pending;     // Transmit-empty interrupt latch
  logic             tx_empty_d;       // Empty state one cycle back
  // Receive FIFO bookkeeping
  logic [PTR_W-1:0] rx_wr_ptr;
  logic [PTR_W-1:0] rx_rd_ptr;
  logic [CNT_W-1:0] rx_cnt;
  logic [CNT_W-1:0] rx_err_cnt;       // Entries carrying any error flag
  logic [RX_W-1:0]  rx_head;          // Head entry from the store
  // Transmit FIFO bookkeeping
  logic [PTR_W-1:0] tx_wr_ptr;
  logic [PTR_W-1:0] tx_rd_ptr;
  logic [CNT_W-1:0] tx_cnt;
  logic [7:0]       tx_head;
  // Two-entry output buffer between the transmit FIFO and the shifter
  logic [1:0]       buf_cnt;
  logic [7:0]       buf_slot1;

  // Register port decode
  wire       div_sel    = o_line_control[LCR_DIV_SELECT];
  wire       sel_data   = (i_addr == OFF_DATA) && !div_sel;
  wire       sel_ier    = (i_addr == OFF_IRQ_ENABLE) && !div_sel;
  wire       sel_dll    = (i_addr == OFF_DATA) && div_sel;
  wire       sel_dlm    = (i_addr == OFF_IRQ_ENABLE) && div_sel;
  wire       wr_fcr     = i_wr && (i_addr == OFF_IRQ_ID);
  wire       rd_iir     = i_rd && (i_addr == OFF_IRQ_ID);
  wire       wr_thr     = i_wr && sel_data;
  wire       rd_rbr     = i_rd && sel_data;
  wire       rd_lsr     = i_rd && (i_addr == OFF_LINE_STAT);
  wire       rd_msr     = i_rd && (i_addr == OFF_MODEM_STAT);

  // FIFO control write effects
  wire       fcr_en_new = i_wr_data[FCR_ENABLE_BIT];
  wire       fcr_change = wr_fcr && (fcr_en_new != fifo_en);
  wire       fcr_prog   = wr_fcr && fcr_en_new;
  wire       rx_flush   = fcr_change || (fcr_prog && i_wr_data[FCR_RX_FLUSH]);
  wire       tx_flush   = fcr_change || (fcr_prog && i_wr_data[FCR_TX_FLUSH]);
  wire       rdy_mode1  = fifo_en && ready_mode_bit;

  // Capacity is one byte in unbuffered mode, sixteen when buffered
  wire [CNT_W-1:0] cap  = fifo_en ? FIFO_FULL : CHAR_FULL;
  wire [CNT_W-1:0] trig_level = (trig_sel == 2'h0) ? TRIG_LEVEL_0 :
                                (trig_sel == 2'h1) ? TRIG_LEVEL_1 :
                                (trig_sel == 2'h2) ? TRIG_LEVEL_2 : TRIG_LEVEL_3;

  // Receive path: arrivals while full are dropped and counted as overrun
  wire       rx_full    = (rx_cnt >= cap);
  wire       rx_push    = i_rx_valid && !rx_full && !rx_flush;
  wire       rx_pop     = rd_rbr && (rx_cnt != 5'h00) && !rx_flush;
  wire       rx_lost    = i_rx_valid && rx_full;
  wire       rx_head_err = (rx_head[10:8] != 3'h0);
  wire       rx_in_err  = (i_rx_err != 3'h0);
  wire [PTR_W-1:0] next_rx_rd = rx_flush ? 4'h0 : (rx_rd_ptr + {3'h0, rx_pop});

  // Transmit path: host writes past capacity are ignored
  wire       tx_take    = o_tx_valid && i_tx_ready;
  wire       tx_push    = wr_thr && (tx_cnt < cap) && !tx_flush;
  wire       tx_pop     = (tx_cnt != 5'h00) && ((buf_cnt != 2'h2) || tx_take) && !tx_flush;
  wire [PTR_W-1:0] next_tx_rd = tx_flush ? 4'h0 : (tx_rd_ptr + {3'h0, tx_pop});
  wire       tx_empty   = (tx_cnt == 5'h00);

  // Output buffer slot moves
  wire       load_slot0 = tx_pop && ((buf_cnt == 2'h0) || ((buf_cnt == 2'h1) && tx_take));
  wire       load_slot1 = tx_pop && (((buf_cnt == 2'h1) && !tx_take) || ((buf_cnt == 2'h2) && tx_take));
  wire       shift_slot = tx_take && (buf_cnt == 2'h2) ;
  wire [1:0] next_buf_cnt = buf_cnt + {1'b0, tx_pop} - {1'b0, tx_take};

  // Modem change detection; ring reports its trailing edge only
  wire [3:0] modem_evt  = {i_modem_lines[3] ^ modem_prev[3],
                           modem_prev[2] & ~i_modem_lines[2],
                           i_modem_lines[1] ^ modem_prev[1],
                           i_modem_lines[0] ^ modem_prev[0]};

  // Interrupt sources, each gated by its enable
  wire       ls_src     = irq_enable[IER_LINE_STAT] &&
                          (overrun || ((rx_cnt != 5'h00) && rx_head_err));
  wire       rda_src    = irq_enable[IER_RX_DATA] &&
                          (fifo_en ? (rx_cnt >= trig_level) : (rx_cnt != 5'h00));
  wire       thre_src   = irq_enable[IER_TX_EMPTY] && thre_pending;
  wire       ms_src     = irq_enable[IER_MODEM_STAT] && (msr_delta != 4'h0);
  wire       irq_any    = ls_src || rda_src || thre_src || ms_src;
  wire [2:0] irq_id     = ls_src  ? ID_LINE_STAT :
                          rda_src ? ID_RX_DATA :
                          thre_src ? ID_TX_EMPTY : ID_MODEM;
  // Time-out is not generated here, so bit 3 stays zero; FIFO flag bits follow the enable
  wire [7:0] iir_val    = {fifo_en, fifo_en, 2'h0, irq_id, ~irq_any};
  wire       thre_set   = (tx_empty && !tx_empty_d) || (tx_empty && fcr_change);
  wire       thre_clr   = wr_thr || (rd_iir && !ls_src && !rda_src && thre_src);

  // Status words
  wire [7:0] lsr_val    = {fifo_en && (rx_err_cnt != 5'h00),
                           tx_empty && (buf_cnt == 2'h0) && i_tx_shift_empty,
                           tx_empty,
                           (rx_cnt != 5'h00) ? rx_head[10:8] : 3'h0,
                           overrun,
                           rx_cnt != 5'h00};
  wire [7:0] msr_val    = {i_modem_lines[3], i_modem_lines[2], i_modem_lines[1], i_modem_lines[0], msr_delta};

  // Read data selection; the data byte keeps bit 0 as its least significant bit
  wire [7:0] rd_mux     = sel_data ? rx_head[7:0] :
                          sel_dll  ? o_baud_divisor[7:0] :
                          sel_ier  ? {4'h0, irq_enable} :
                          sel_dlm  ? o_baud_divisor[15:8] :
                          (i_addr == OFF_IRQ_ID)     ? iir_val :
                          (i_addr == OFF_LINE_CTRL)  ? o_line_control :
                          (i_addr == OFF_MODEM_CTRL) ? {2'h0, o_modem_control} :
                          (i_addr == OFF_LINE_STAT)  ? lsr_val :
                          (i_addr == OFF_MODEM_STAT) ? msr_val : scratch;

  // Receive store
  fifo_store #(.W(RX_W)) u_rx_store (
    .i_mclk  (i_mclk),
    .i_we    (rx_push),
    .i_waddr (rx_wr_ptr),
    .i_wdata ({i_rx_err, i_rx_data}),
    .i_raddr (next_rx_rd),
    .o_rdata (rx_head)
  );

  // Transmit store
  fifo_store #(.W(8)) u_tx_store (
    .i_mclk  (i_mclk),
    .i_we    (tx_push),
    .i_waddr (tx_wr_ptr),
    .i_wdata (i_wr_data),
    .i_raddr (next_tx_rd),
    .o_rdata (tx_head)
  );

  // Host-written registers; divisor and scratch are cleared too so nothing starts unknown
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      irq_enable      <= 4'h0;
      o_line_control  <= RST_BYTE;
      o_modem_control <= RST_MCR;
      o_baud_divisor  <= RST_DIVISOR;
      scratch         <= RST_BYTE;
    end else if (i_wr) begin
      if (sel_ier) begin
        irq_enable <= i_wr_data[3:0];
      end
      if (sel_dll) begin
        o_baud_divisor[7:0] <= i_wr_data;
      end
      if (sel_dlm) begin
        o_baud_divisor[15:8] <= i_wr_data;
      end
      if (i_addr == OFF_LINE_CTRL) begin
        o_line_control <= i_wr_data;
      end
      if (i_addr == OFF_MODEM_CTRL) begin
        o_modem_control <= i_wr_data[5:0];
      end
      if (i_addr == OFF_SCRATCH) begin
        scratch <= i_wr_data;
      end
    end
  end

  // FIFO control; flush bits act as pulses and are never stored, reserved bits ignored
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      fifo_en        <= 1'b0;
      ready_mode_bit <= 1'b0;
      trig_sel       <= RST_TRIG;
    end else if (wr_fcr) begin
      fifo_en <= fcr_en_new;
      if (fcr_en_new) begin
        ready_mode_bit <= i_wr_data[FCR_READY_MODE];
        trig_sel       <= i_wr_data[FCR_TRIG_LSB +: 2];
      end
    end
  end

  // Receive pointers; the receive shifter outside is untouched by a flush
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n || rx_flush) begin
      rx_wr_ptr  <= 4'h0;
      rx_rd_ptr  <= 4'h0;
      rx_cnt     <= 5'h00;
      rx_err_cnt <= 5'h00;
    end else begin
      rx_wr_ptr  <= rx_wr_ptr + {3'h0, rx_push};
      rx_rd_ptr  <= next_rx_rd;
      rx_cnt     <= rx_cnt + {4'h0, rx_push} - {4'h0, rx_pop};
      rx_err_cnt <= rx_err_cnt + {4'h0, rx_push && rx_in_err} - {4'h0, rx_pop && rx_head_err};
    end
  end

  // Transmit pointers; the output buffer stands for the shifter and keeps its bytes
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n || tx_flush) begin
      tx_wr_ptr <= 4'h0;
      tx_rd_ptr <= 4'h0;
      tx_cnt    <= 5'h00;
    end else begin
      tx_wr_ptr <= tx_wr_ptr + {3'h0, tx_push};
      tx_rd_ptr <= next_tx_rd;
      tx_cnt    <= tx_cnt + {4'h0, tx_push} - {4'h0, tx_pop};
    end
  end

  // Two-entry output buffer; a stalled shifter holds bytes back in the FIFO, not lost
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      buf_cnt    <= 2'h0;
      o_tx_valid <= 1'b0;
      o_tx_data  <= RST_BYTE;
      buf_slot1  <= RST_BYTE;
    end else begin
      buf_cnt    <= next_buf_cnt;
      o_tx_valid <= (next_buf_cnt != 2'h0);
      if (load_slot0) begin
        o_tx_data <= tx_head;
      end else if (shift_slot) begin
        o_tx_data <= buf_slot1;
      end
      if (load_slot1) begin
        buf_slot1 <= tx_head;
      end
    end
  end

  // Sticky status flags; a new event in the clearing cycle wins
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      overrun      <= 1'b0;
      msr_delta    <= 4'h0;
      modem_prev   <= 4'h0;
      thre_pending <= 1'b0;
      tx_empty_d   <= 1'b1;
    end else begin
      overrun      <= rx_lost || (overrun && !rd_lsr);
      msr_delta    <= modem_evt | (rd_msr ? 4'h0 : msr_delta);
      modem_prev   <= i_modem_lines;
      thre_pending <= thre_set || (thre_pending && !thre_clr);
      tx_empty_d   <= tx_empty;
    end
  end

  // Read data, interrupt line and ready pins, all from flip-flops
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_rd_data              <= RST_BYTE;
      o_irq                  <= 1'b0;
      o_receive_ready_out_n  <= 1'b1;
      o_transmit_ready_out_n <= 1'b0;
    end else begin
      if (i_rd) begin
        o_rd_data <= rd_mux;
      end
      o_irq <= irq_any;
      // Mode 1 uses the trigger level and the full mark; mode 0 a single byte
      if (rdy_mode1) begin
        if (rx_cnt >= trig_level) begin
          o_receive_ready_out_n <= 1'b0;
        end else if (rx_cnt == 5'h00) begin
          o_receive_ready_out_n <= 1'b1;
        end
        o_transmit_ready_out_n <= (tx_cnt >= FIFO_FULL);
      end else begin
        o_receive_ready_out_n  <= (rx_cnt == 5'h00);
        o_transmit_ready_out_n <= !tx_empty;
      end
    end
  end

  // Checks kept beside the logic
  a_fcr_needs_enable: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (wr_fcr && !i_wr_data[0] && !fifo_en) |=> ($stable(trig_sel) && $stable(ready_mode_bit)))
    else $error("control bits changed without the enable bit");
  a_enable_flush: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (wr_fcr && (i_wr_data[0] != fifo_en)) |=> (rx_cnt == 5'h00 && tx_cnt == 5'h00 && fifo_en == $past(i_wr_data[0])))
    else $error("enable change did not empty both FIFOs");
  a_rx_flush_zero: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (wr_fcr && fifo_en && i_wr_data[0] && i_wr_data[1]) |=> (rx_cnt == 5'h00 && !o_line_control[6] == !$past(o_line_control[6])))
    else $error("receive flush left bytes");
  a_tx_flush_zero: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (wr_fcr && fifo_en && i_wr_data[0] && i_wr_data[2]) |=> (tx_cnt == 5'h00))
    else $error("transmit flush left bytes");
  a_ready_mode_zero: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (!rdy_mode1 && tx_cnt != 5'h00) |=> o_transmit_ready_out_n)
    else $error("mode 0 transmit ready low with bytes queued");
  a_trigger_fourteen: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (fifo_en && trig_sel == 2'h3 && rx_cnt == 5'h0D) |-> !rda_src)
    else $error("receive interrupt before fourteen bytes");
  a_ier_upper_zero: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_rd && sel_ier) |=> (o_rd_data[7:4] == 4'h0))
    else $error("enable register upper nibble not zero");
  a_iir_char_mode: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (rd_iir && !fifo_en) |=> (o_rd_data[7:6] == 2'h0 && o_rd_data[3] == 1'b0))
    else $error("buffered-only identification bits set in unbuffered mode");
  a_divisor_low: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_wr && sel_dll) |=> (o_baud_divisor[7:0] == $past(i_wr_data) && $stable(o_baud_divisor[15:8])))
    else $error("divisor low byte not written");
endmodule : uart_register_map_fifo_control

/* File: dv/uart_far_end.sv */
`timescale 1ns/1ps
// Far side of the block: receive shifter handing bytes in, transmit shifter taking them
module uart_far_end (
  input  wire logic       i_mclk,
  input  wire logic       i_stall,
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_data,
  output logic            o_rx_valid,
  output logic      [7:0] o_rx_data,
  output logic      [2:0] o_rx_err,
  output logic            o_tx_ready,
  output logic            o_tx_shift_empty
);
  logic [7:0] got[$];            // Bytes taken by the transmit shifter, in order
  logic [2:0] err_next = 3'h0;   // Error flags handed in with the next byte
  initial begin
    o_rx_valid       = 1'b0;
    o_rx_data        = 8'h00;
    o_rx_err         = 3'h7;
    o_tx_shift_empty = 1'b1;
  end
  // Stall on request so the output buffer has to back up
  assign o_tx_ready = ~i_stall;
  // One byte per transfer; shifter looks busy for a cycle after each
  always @(posedge i_mclk) begin
    o_tx_shift_empty <= ~(i_tx_valid & o_tx_ready);
    if (i_tx_valid && o_tx_ready) got.push_back(i_tx_data);
  end
  // One-cycle pulse; lines show the inverse outside it so stale data never looks valid
  task send(input logic [7:0] b);
    @(posedge i_mclk);
    o_rx_valid <= 1'b1;
    o_rx_data  <= b;
    o_rx_err   <= err_next;
    @(posedge i_mclk);
    o_rx_valid <= 1'b0;
    o_rx_data  <= ~b;
    o_rx_err   <= 3'h7;
  endtask : send
endmodule : uart_far_end

/* File: dv/test_uart_register_map_fifo_control.sv */
`timescale 1ns/1ps
module test_uart_register_map_fifo_control;
  import uart_regs_pkg::*;
  logic        i_mclk = 1'b0;    // 250 MHz clock
  logic        i_rst_n = 1'b0;   // Held low for two edges
  logic [2:0]  i_addr;
  logic        i_wr;
  logic        i_rd;
  logic [7:0]  i_wr_data;
  logic        stall;            // Transmit shifter refuses while high
  logic [3:0]  modem;            // Modem line levels into the block
  logic        rx_valid, tx_valid, tx_ready, shift_empty, irq, rr_n, tr_n;
  logic [7:0]  rx_data, rd_data, tx_data, lc, d;
  logic [2:0]  rx_err;
  logic [15:0] div;
  logic [5:0]  mc;
  int          n_mismatch = 0;
  int          checked = 0;
  int          lvl[4] = '{1, 4, 8, 14};  // Trigger levels per select code
  always #2 i_mclk = ~i_mclk;
  uart_register_map_fifo_control dut_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr(i_wr),
    .i_rd(i_rd), .i_wr_data(i_wr_data), .o_rd_data(rd_data), .i_rx_valid(rx_valid), .i_rx_data(rx_data),
    .i_rx_err(rx_err), .o_tx_valid(tx_valid), .o_tx_data(tx_data), .i_tx_ready(tx_ready),
    .i_tx_shift_empty(shift_empty), .i_modem_lines(modem), .o_irq(irq), .o_receive_ready_out_n(rr_n),
    .o_transmit_ready_out_n(tr_n), .o_baud_divisor(div), .o_line_control(lc), .o_modem_control(mc));
  uart_far_end far_u (.i_mclk(i_mclk), .i_stall(stall), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
    .o_rx_valid(rx_valid), .o_rx_data(rx_data), .o_rx_err(rx_err), .o_tx_ready(tx_ready),
    .o_tx_shift_empty(shift_empty));
  // Single compare point; case inequality so unknowns fail
  task chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  // One-cycle write strobe
  task wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge i_mclk);
    i_addr    <= a;
    i_wr_data <= v;
    i_wr      <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask : wr
  // Read data lands on the edge that takes the strobe
  task rd(input logic [2:0] a);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 d = rd_data;
  endtask : rd
  task finish_test;
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test
  // Watchdog: the tests need a few hundred cycles at most
  initial begin
    #100000;
    n_mismatch++;
    finish_test();
  end
  // Main sequence
  initial begin
    i_addr    <= 3'h0;  // Bus idle while reset is held
    i_wr      <= 1'b0;
    i_rd      <= 1'b0;
    i_wr_data <= 8'h00;
    stall     <= 1'b0;
    modem     <= 4'h0;
    repeat (2) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    rd(OFF_IRQ_ID); chk("iir_reset", d, 8'h01);
    wr(OFF_IRQ_ENABLE, 8'hFF);
    rd(OFF_IRQ_ENABLE); chk("ier_upper", d, 8'h0F);
    @(posedge i_mclk) modem <= 4'h1;  // Clear-to-send rises, modem change pending
    rd(OFF_IRQ_ID); chk("iir_modem", d, 8'h00);
    chk("irq_modem", 16'(irq), 16'h1);
    rd(OFF_MODEM_STAT); chk("msr_delta", d, 8'h11);
    rd(OFF_IRQ_ID); chk("iir_clear", d, 8'h01);
    chk("irq_clear", 16'(irq), 16'h0);
    wr(OFF_IRQ_ENABLE, 8'h00);
    // Divisor bytes overlay offsets 0 and 1 while select is set
    wr(OFF_LINE_CTRL, 8'h80);
    wr(OFF_DATA, 8'h34);
    wr(OFF_IRQ_ENABLE, 8'h12);
    wr(OFF_MODEM_CTRL, 8'hFF);  // Offsets past 1 keep their meaning while select is set
    #1 chk("divisor", div, 16'h1234);
    chk("mcr", 16'(mc), 16'h3F);
    rd(OFF_DATA); chk("div_low", d, 8'h34);
    wr(OFF_LINE_CTRL, 8'h03);
    rd(OFF_IRQ_ENABLE); chk("ier_kept", d, 8'h00);
    chk("lcr", 16'(lc), 16'h03);
    // Other control bits without the enable must be ignored
    wr(OFF_IRQ_ID, 8'hC8);
    rd(OFF_IRQ_ID); chk("iir_noen", d, 8'h01);
    // Unbuffered: one byte held, second dropped with overrun
    far_u.send(8'hA5);
    repeat (3) @(posedge i_mclk);
    chk("rx_ready_m0", 16'(rr_n), 16'h0);
    far_u.send(8'h5A);
    rd(OFF_DATA); chk("rbr", d, 8'hA5);
    rd(OFF_LINE_STAT); chk("lsr_ovr", 16'(d[1:0]), 16'h2);
    // Each trigger level in ready mode 1, flushed each time, data interrupt enabled
    wr(OFF_IRQ_ENABLE, 8'h01);
    for (int t = 0; t < 4; t++) begin
      wr(OFF_IRQ_ID, {t[1:0], 6'h0B});
      for (int k = 1; k < lvl[t]; k++) far_u.send(8'h40 + 8'(k));
      repeat (3) @(posedge i_mclk);
      chk("below_trig", 16'(rr_n), 16'h1);
      chk("irq_below", 16'(irq), 16'h0);
      far_u.send(8'h3F);
      repeat (3) @(posedge i_mclk);
      chk("at_trig", 16'(rr_n), 16'h0);
      chk("irq_at", 16'(irq), 16'h1);
      wr(OFF_IRQ_ID, 8'h03);
      rd(OFF_LINE_STAT); chk("rx_flushed", 16'(d[0]), 16'h0);
    end
    rd(OFF_IRQ_ID); chk("iir_fifo", d, 8'hC1);
    wr(OFF_IRQ_ENABLE, 8'h00);
    // Stalled transmit: two bytes in the buffer, third flushed from the FIFO
    @(posedge i_mclk) stall <= 1'b1;
    wr(OFF_DATA, 8'h11);
    wr(OFF_DATA, 8'h22);
    wr(OFF_DATA, 8'h33);
    repeat (3) @(posedge i_mclk);
    chk("tx_ready_busy", 16'(tr_n), 16'h1);
    wr(OFF_IRQ_ID, 8'h05);
    stall <= 1'b0;
    repeat (10) @(posedge i_mclk);
    chk("tx_count", 16'(far_u.got.size()), 16'h2);
    chk("tx_first", 16'(far_u.got[0]), 16'h11);
    chk("tx_second", 16'(far_u.got[1]), 16'h22);
    chk("tx_ready_idle", 16'(tr_n), 16'h0);
    // Reserved bits with the enable unchanged must not flush; byte carries a break flag
    far_u.err_next = 3'h4;
    far_u.send(8'h77);
    far_u.err_next = 3'h0;
    wr(OFF_IRQ_ID, 8'h31);
    rd(OFF_LINE_STAT); chk("lsr_err", d, 8'hF1);
    rd(OFF_DATA); chk("reserved", d, 8'h77);
    // Clearing the enable empties the FIFOs and hides FIFO status
    far_u.send(8'h01);
    far_u.send(8'h02);
    wr(OFF_IRQ_ID, 8'h00);
    rd(OFF_LINE_STAT); chk("lsr_off", 16'({d[7], d[0]}), 16'h0);
    rd(OFF_IRQ_ID); chk("iir_off", d, 8'h01);
    finish_test();
  end
endmodule : test_uart_register_map_fifo_control
